// file: pkg/vpsic_pkg.sv
// Constants for the video port sync and init control block.
// Assumes one 40 MHz clock; the pixel clock is derived from it by a divider.

package vpsic_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADDR_FLOAT     = 8'h55;
   localparam logic [7:0] ADDR_INIT_ONE  = 8'h80;
   localparam logic [7:0] ADDR_OFFSET    = 8'h83;
   localparam logic [7:0] ADDR_PWR       = 8'h85;
   localparam logic [7:0] ADDR_INIT_TWO  = 8'h88;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and codes
   localparam logic [7:0] RST_FLOAT      = 8'h00;
   localparam logic [7:0] RST_INIT_ONE   = 8'h00;
   localparam logic [7:0] RST_OFFSET     = 8'h1E;
   localparam logic [7:0] RST_PWR        = 8'h81;
   localparam logic [7:0] RST_INIT_TWO   = 8'h00;
   localparam logic [7:0] CODE_CAL_ON    = 8'h05;
   localparam logic [7:0] CODE_ACCESS_ON = 8'h01;
   localparam logic [7:0] CODE_ACCESS_OFF = 8'h00;
   localparam logic [7:0] CODE_PD_LOW    = 8'h82;
   localparam logic [7:0] FLOAT_MASK     = 8'h1F;

   ////////////////////////////////////////////////////////////////////////////
   // Float register fields
   localparam int BIT_TRISTATE  = 4;
   localparam int BIT_FS_KEEP   = 3;
   localparam int BIT_LS_KEEP   = 2;
   localparam int BIT_PCLK_KEEP = 1;
   localparam int BIT_EXT_KEEP  = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Widths and timing
   localparam int PIX_W       = 10;
   localparam int COL_W       = 13;
   localparam int FRM_W       = 26;
   localparam int BUF_DEPTH   = 2;
   localparam logic [12:0] BLACK_PIXELS = 13'h0008;
   localparam logic [12:0] PIX_LEAD     = 13'h0001;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PIX_PERIOD_NS = 50;
   localparam int CLKS_PER_PIXEL = PIX_PERIOD_NS / CLK_PERIOD_NS;

endpackage : vpsic_pkg

// file: rtl/vpsic_buf2.sv
// Two-entry valid/ready buffer between the pixel source and the video port.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps

module vpsic_buf2 #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   logic [W-1:0] mem_r [vpsic_pkg::BUF_DEPTH];
   logic         wr_idx_r;
   logic         rd_idx_r;
   logic [1:0]   count_r;
   logic         push;
   logic         pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (count_r != 2'(vpsic_pkg::BUF_DEPTH));
   assign out_valid = (count_r != 2'h0);
   assign out_data  = mem_r[rd_idx_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_idx_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_idx_r <= 1'b0;
         rd_idx_r <= 1'b0;
         count_r  <= 2'h0;
      end else begin
         if (push) begin
            wr_idx_r <= ~wr_idx_r;
         end
         if (pop) begin
            rd_idx_r <= ~rd_idx_r;
         end
         count_r <= count_r + 2'(push) - 2'(pop);
      end
   end

endmodule : vpsic_buf2

// file: rtl/vpsic_top.sv
// Video port sync timing, output float control and init/calibration registers.
// Assumes a byte-wide register port from the serial control logic and a
// pixel source that presents words with valid/ready.
`timescale 1ns/100ps

module vpsic_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   // Timing configuration
   input  wire logic        master_mode,
   input  wire logic        black_pixel_enable,
   input  wire logic [7:0]  line_edge_start_offset,
   input  wire logic [7:0]  line_edge_end_offset,
   input  wire logic [7:0]  frame_edge_start_offset,
   input  wire logic [7:0]  frame_edge_end_offset,
   input  wire logic [11:0] row_length_periods,
   input  wire logic [9:0]  active_pixel_count,
   input  wire logic [9:0]  row_count,
   input  wire logic [7:0]  frame_delay_rows,
   input  wire logic [11:0] readout_overhead,
   input  wire logic [15:0] integration_time,
   // Pixel source
   input  wire logic        adc_valid,
   output logic             adc_ready,
   input  wire logic [9:0]  adc_data,
   input  wire logic        ext_sync_in,
   // Video port
   output logic             frame_sync,
   output logic             frame_sync_oe_n,
   output logic             line_sync,
   output logic             line_sync_oe_n,
   output logic             pixel_clock,
   output logic             pixel_clock_oe_n,
   output logic [9:0]       pixel_data,
   output logic             pixel_data_oe_n,
   output logic             external_sync,
   output logic             external_sync_oe_n,
   // Control outputs
   output logic             calibration_enable,
   output logic             init_regs_active,
   output logic [7:0]       offset_compensation_value,
   output logic             power_down_low_current
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] float_r;
   logic [7:0] init_one_r;
   logic [7:0] offset_r;
   logic [7:0] pwr_r;
   logic [7:0] init_two_r;
   logic [7:0] rdata_r;
   logic       rvalid_r;
   logic       access_ok;
   logic       wr_float;
   logic       wr_init_one;
   logic       wr_offset;
   logic       wr_pwr;
   logic       wr_init_two;

   assign access_ok   = (init_two_r == vpsic_pkg::CODE_ACCESS_ON);
   assign wr_float    = reg_write && (reg_addr == vpsic_pkg::ADDR_FLOAT);
   assign wr_init_one = reg_write && (reg_addr == vpsic_pkg::ADDR_INIT_ONE) && access_ok;
   assign wr_offset   = reg_write && (reg_addr == vpsic_pkg::ADDR_OFFSET);
   assign wr_pwr      = reg_write && (reg_addr == vpsic_pkg::ADDR_PWR);
   assign wr_init_two = reg_write && (reg_addr == vpsic_pkg::ADDR_INIT_TWO);

   always_ff @(posedge clk) begin
      if (reset) begin
         float_r    <= vpsic_pkg::RST_FLOAT;
         init_one_r <= vpsic_pkg::RST_INIT_ONE;
         offset_r   <= vpsic_pkg::RST_OFFSET;
         pwr_r      <= vpsic_pkg::RST_PWR;
         init_two_r <= vpsic_pkg::RST_INIT_TWO;
      end else begin
         if (wr_float) begin
            float_r <= reg_wdata & vpsic_pkg::FLOAT_MASK;
         end
         if (wr_init_one) begin
            init_one_r <= reg_wdata;
         end
         if (wr_offset) begin
            offset_r <= reg_wdata;
         end
         if (wr_pwr) begin
            pwr_r <= reg_wdata;
         end
         if (wr_init_two) begin
            init_two_r <= reg_wdata;
         end
      end
   end

   // Gated register reads back as zero so a locked state is visible
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_read;
         rdata_r  <= 8'h00;
         if (reg_read) begin
            unique case (reg_addr)
               vpsic_pkg::ADDR_FLOAT:    rdata_r <= float_r;
               vpsic_pkg::ADDR_INIT_ONE: rdata_r <= access_ok ? init_one_r : 8'h00;
               vpsic_pkg::ADDR_OFFSET:   rdata_r <= offset_r;
               vpsic_pkg::ADDR_PWR:      rdata_r <= pwr_r;
               vpsic_pkg::ADDR_INIT_TWO: rdata_r <= init_two_r;
               default:                  rdata_r <= 8'h00;
            endcase
         end
      end
   end

   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Control outputs

   logic cal_en_r;
   logic init_act_r;
   logic pd_low_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         cal_en_r   <= 1'b0;
         init_act_r <= 1'b0;
         pd_low_r   <= 1'b0;
      end else begin
         cal_en_r   <= access_ok && (init_one_r == vpsic_pkg::CODE_CAL_ON);
         init_act_r <= access_ok;
         pd_low_r   <= (pwr_r == vpsic_pkg::CODE_PD_LOW);
      end
   end

   assign calibration_enable        = cal_en_r;
   assign init_regs_active          = init_act_r;
   assign offset_compensation_value = offset_r;
   assign power_down_low_current    = pd_low_r;

   ////////////////////////////////////////////////////////////////////////////
   // Interval lengths in pixel periods

   logic [12:0] blk_n;
   logic [12:0] line_act_len;
   logic [12:0] first_pix;
   logic [12:0] black_end;
   logic [12:0] pix_end;
   logic [25:0] frame_act_len;
   logic [25:0] frame_inact_len;
   logic [25:0] frame_len;

   // Config is assumed consistent; a negative span would wrap, not clamp
   always_comb begin
      blk_n           = black_pixel_enable ? vpsic_pkg::BLACK_PIXELS : 13'h0000;
      line_act_len    = 13'(line_edge_end_offset) - 13'(line_edge_start_offset)
                        + blk_n + 13'(active_pixel_count);
      first_pix       = 13'(line_edge_start_offset) - vpsic_pkg::PIX_LEAD;
      black_end       = first_pix + blk_n;
      pix_end         = black_end + 13'(active_pixel_count);
      frame_act_len   = 26'(frame_edge_end_offset) - 26'(frame_edge_start_offset)
                        + 26'(row_length_periods) * 26'(row_count);
      frame_inact_len = 26'(frame_delay_rows) * 26'(row_length_periods) + 26'(readout_overhead)
                        + 26'(integration_time) + 26'(frame_edge_start_offset)
                        - 26'(frame_edge_end_offset);
      frame_len       = frame_act_len + frame_inact_len;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pixel clock divider and counters

   logic        pclk_r;
   logic        tick;
   logic [12:0] col_r;
   logic [25:0] fcnt_r;

   // Frame sync, line sync and pixel data change with the falling pixel clock edge for rising-edge capture
   assign tick = pclk_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         pclk_r <= 1'b0;
      end else begin
         pclk_r <= ~pclk_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         col_r  <= 13'h0000;
         fcnt_r <= 26'h000_0000;
      end else if (tick) begin
         col_r  <= (col_r >= 13'(row_length_periods) - 13'h0001) ? 13'h0000 : col_r + 13'h0001;
         fcnt_r <= (fcnt_r >= frame_len - 26'h000_0001) ? 26'h000_0000 : fcnt_r + 26'h000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pixel path

   logic       buf_valid;
   logic [9:0] buf_data;
   logic       fs_now;
   logic       in_window;
   logic       in_black;
   logic       pix_take;
   logic [9:0] comp_value;

   vpsic_buf2 #(
      .W (vpsic_pkg::PIX_W)
   ) u_buf (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (adc_valid),
      .in_ready  (adc_ready),
      .in_data   (adc_data),
      .out_valid (buf_valid),
      .out_ready (pix_take),
      .out_data  (buf_data)
   );

   assign fs_now     = (fcnt_r < frame_act_len);
   assign in_window  = fs_now && (col_r >= first_pix) && (col_r < pix_end);
   assign in_black   = (col_r < black_end);
   assign pix_take   = tick && in_window && !in_black && buf_valid;
   // Offset subtraction saturates at zero rather than wrapping to white
   assign comp_value = (buf_data > 10'(offset_r)) ? buf_data - 10'(offset_r) : 10'h000;

   logic       fs_r;
   logic       ls_r;
   logic [9:0] data_r;
   logic       ext_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         fs_r   <= 1'b0;
         ls_r   <= 1'b0;
         data_r <= 10'h000;
         ext_r  <= 1'b0;
      end else begin
         ext_r <= ext_sync_in;
         if (tick) begin
            fs_r   <= fs_now;
            ls_r   <= (col_r < line_act_len);
            // Underrun shows as a black pixel; the row timing never slips
            data_r <= pix_take ? comp_value : 10'h000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output float control

   logic fs_oe_n_r;
   logic ls_oe_n_r;
   logic pclk_oe_n_r;
   logic data_oe_n_r;
   logic ext_oe_n_r;
   logic flt;

   assign flt = float_r[vpsic_pkg::BIT_TRISTATE];

   always_ff @(posedge clk) begin
      if (reset) begin
         fs_oe_n_r   <= 1'b0;
         ls_oe_n_r   <= 1'b0;
         pclk_oe_n_r <= 1'b0;
         data_oe_n_r <= 1'b0;
         ext_oe_n_r  <= 1'b0;
      end else begin
         fs_oe_n_r   <= flt && !(master_mode && float_r[vpsic_pkg::BIT_FS_KEEP]);
         ls_oe_n_r   <= flt && !(master_mode && float_r[vpsic_pkg::BIT_LS_KEEP]);
         pclk_oe_n_r <= flt && !(master_mode && float_r[vpsic_pkg::BIT_PCLK_KEEP]);
         ext_oe_n_r  <= flt && !(master_mode && float_r[vpsic_pkg::BIT_EXT_KEEP]);
         data_oe_n_r <= flt;
      end
   end

   assign frame_sync         = fs_r;
   assign frame_sync_oe_n    = fs_oe_n_r;
   assign line_sync          = ls_r;
   assign line_sync_oe_n     = ls_oe_n_r;
   assign pixel_clock        = pclk_r;
   assign pixel_clock_oe_n   = pclk_oe_n_r;
   assign pixel_data         = data_r;
   assign pixel_data_oe_n    = data_oe_n_r;
   assign external_sync      = ext_r;
   assign external_sync_oe_n = ext_oe_n_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic        ls_q_r;
   logic        fs_q_r;
   logic        ls_seen_r;
   logic        fs_seen_r;
   logic [25:0] ls_run_r;
   logic [25:0] fs_run_r;

   // Run counters measure clock cycles between sync edges
   always_ff @(posedge clk) begin
      if (reset) begin
         ls_q_r    <= 1'b0;
         fs_q_r    <= 1'b0;
         ls_seen_r <= 1'b0;
         fs_seen_r <= 1'b0;
         ls_run_r  <= 26'h000_0000;
         fs_run_r  <= 26'h000_0000;
      end else begin
         ls_q_r    <= ls_r;
         fs_q_r    <= fs_r;
         ls_seen_r <= ls_seen_r || (ls_r != ls_q_r);
         fs_seen_r <= fs_seen_r || (fs_r != fs_q_r);
         ls_run_r  <= (ls_r != ls_q_r) ? 26'h000_0001 : ls_run_r + 26'h000_0001;
         fs_run_r  <= (fs_r != fs_q_r) ? 26'h000_0001 : fs_run_r + 26'h000_0001;
      end
   end

   float_data_a: assert property (@(posedge clk) disable iff (reset)
      flt |=> pixel_data_oe_n)
      else $error("pixel data driven while floated");

   float_sync_a: assert property (@(posedge clk) disable iff (reset)
      flt && !master_mode |=> frame_sync_oe_n && line_sync_oe_n && pixel_clock_oe_n && external_sync_oe_n)
      else $error("sync port driven while floated");

   keep_drive_a: assert property (@(posedge clk) disable iff (reset)
      flt && master_mode && float_r[vpsic_pkg::BIT_FS_KEEP] |=> !frame_sync_oe_n)
      else $error("frame sync keep bit ignored");

   cal_code_a: assert property (@(posedge clk) disable iff (reset)
      wr_init_one && (reg_wdata == vpsic_pkg::CODE_CAL_ON) |=> ##1 calibration_enable)
      else $error("calibration not enabled by code");

   init_gate_a: assert property (@(posedge clk) disable iff (reset)
      reg_write && (reg_addr == vpsic_pkg::ADDR_INIT_ONE) && !access_ok |=> $stable(init_one_r))
      else $error("locked init register changed");

   offset_apply_a: assert property (@(posedge clk) disable iff (reset)
      pix_take |=> pixel_data == $past(comp_value))
      else $error("pixel offset not applied");

   access_on_a: assert property (@(posedge clk) disable iff (reset)
      wr_init_two && (reg_wdata == vpsic_pkg::CODE_ACCESS_ON) |=> ##1 init_regs_active)
      else $error("init registers not activated");

   access_off_a: assert property (@(posedge clk) disable iff (reset)
      wr_init_two && (reg_wdata == vpsic_pkg::CODE_ACCESS_OFF) |=> ##1 !init_regs_active)
      else $error("init registers not disabled");

   line_high_a: assert property (@(posedge clk) disable iff (reset)
      ls_seen_r && !ls_r && ls_q_r |-> ls_run_r == 26'(line_act_len) * 26'(vpsic_pkg::CLKS_PER_PIXEL))
      else $error("line sync active length wrong");

   line_low_a: assert property (@(posedge clk) disable iff (reset)
      ls_seen_r && ls_r && !ls_q_r |->
      ls_run_r == (26'(row_length_periods) - 26'(line_act_len)) * 26'(vpsic_pkg::CLKS_PER_PIXEL))
      else $error("line sync inactive length wrong");

   frame_high_a: assert property (@(posedge clk) disable iff (reset)
      fs_seen_r && !fs_r && fs_q_r |-> fs_run_r == frame_act_len * 26'(vpsic_pkg::CLKS_PER_PIXEL))
      else $error("frame sync active length wrong");

   frame_low_a: assert property (@(posedge clk) disable iff (reset)
      fs_seen_r && fs_r && !fs_q_r |-> fs_run_r == frame_inact_len * 26'(vpsic_pkg::CLKS_PER_PIXEL))
      else $error("frame sync inactive length wrong");

   // First active pixel lands start minus one, plus black, periods after line sync rose
   first_pix_a: assert property (@(posedge clk) disable iff (reset)
      pix_take && (col_r == black_end) && (black_end != 13'h0000) |->
      ls_q_r && (ls_run_r == 26'(black_end) * 26'(vpsic_pkg::CLKS_PER_PIXEL) - 26'h000_0001))
      else $error("first pixel misplaced after line sync");

endmodule : vpsic_top

// file: verification/vpsic_capture.sv
// Capturing side of the video port: measures sync spans and the first pixel.
// Assumes it sees the resolved port wires, sampled on the 40 MHz clock.
`timescale 1ns/100ps

module vpsic_span (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   reset,
   // Watched level
   input  wire logic   lvl,
   // Last whole spans, in clk cycles
   output logic [15:0] hi,
   output logic [15:0] lo
);
   logic [15:0] cnt_r;
   logic        lvl_r;
   logic        seen_r;
   // The first span after reset is partial, so it is never reported
   always_ff @(posedge clk) begin
      lvl_r <= lvl;
      if (reset) begin
         cnt_r  <= 16'h0001;
         seen_r <= 1'b0;
         hi     <= 16'h0000;
         lo     <= 16'h0000;
      end else if (lvl !== lvl_r) begin
         if (seen_r && lvl_r) hi <= cnt_r;
         if (seen_r && !lvl_r) lo <= cnt_r;
         seen_r <= 1'b1;
         cnt_r  <= 16'h0001;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end
endmodule : vpsic_span

////////////////////////////////////////////////////////////////////////////////
module vpsic_capture (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Video port wires
   input  wire logic       line_sync,
   input  wire logic       frame_sync,
   input  wire logic [9:0] pixel_data,
   // Measurements
   output logic [15:0]     ls_hi,
   output logic [15:0]     ls_lo,
   output logic [15:0]     fs_hi,
   output logic [15:0]     fs_lo,
   output logic [15:0]     pix_dly,
   output logic [9:0]      pix_val
);
   logic        ls_r;
   logic        armed_r;
   logic [15:0] dly_r;
   vpsic_span i_ls (.clk, .reset, .lvl(line_sync), .hi(ls_hi), .lo(ls_lo));
   vpsic_span i_fs (.clk, .reset, .lvl(frame_sync), .hi(fs_hi), .lo(fs_lo));
   // Delay from line sync rise to the first non-black pixel of a framed row
   always_ff @(posedge clk) begin
      ls_r <= line_sync;
      if (reset) begin
         armed_r <= 1'b0;
         pix_dly <= 16'h0000;
         pix_val <= 10'h000;
      end else if (line_sync && !ls_r && frame_sync) begin
         armed_r <= 1'b1;
         dly_r   <= 16'h0001;
      end else if (!frame_sync) begin
         armed_r <= 1'b0;
      end else if (armed_r && pixel_data != 10'h000) begin
         armed_r <= 1'b0;
         pix_dly <= dly_r;
         pix_val <= pixel_data;
      end else begin
         dly_r <= dly_r + 16'h0001;
      end
   end
endmodule : vpsic_capture

// file: verification/tb_video_port_sync_and_init_ctrl.sv
// Self-checking bench for the video port sync and init control block.
// Assumes the capture model alongside; inputs change on the falling edge.
`timescale 1ns/100ps

module tb_video_port_sync_and_init_ctrl;
   logic clk, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, master_mode = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic black_pixel_enable = 1'b1, adc_valid = 1'b1, ext_sync_in = 1'b0;
   logic [7:0] line_edge_start_offset = 8'h04, line_edge_end_offset = 8'h06;
   logic [7:0] frame_edge_start_offset = 8'h02, frame_edge_end_offset = 8'h03;
   logic [11:0] row_length_periods = 12'h028, readout_overhead = 12'h005;
   logic [9:0] active_pixel_count = 10'h00A, row_count = 10'h002, adc_data = 10'h100;
   logic [7:0] frame_delay_rows = 8'h01;
   logic [15:0] integration_time = 16'h000A, ls_hi, ls_lo, fs_hi, fs_lo, pix_dly;
   logic reg_rvalid, adc_ready, frame_sync, frame_sync_oe_n, line_sync, line_sync_oe_n;
   logic pixel_clock, pixel_clock_oe_n, pixel_data_oe_n, external_sync, external_sync_oe_n;
   logic calibration_enable, init_regs_active, power_down_low_current;
   logic [9:0] pixel_data, pix_val;
   logic [7:0] offset_compensation_value;
   int miscompares = 0;
   int n_tests = 0;
   // Released port wires read as floating at the capture side
   wire ls_w = line_sync_oe_n ? 1'bz : line_sync;
   wire fs_w = frame_sync_oe_n ? 1'bz : frame_sync;

   vpsic_top i_dut (.*);
   vpsic_capture i_cap (.clk, .reset, .line_sync(ls_w), .frame_sync(fs_w), .pixel_data,
      .ls_hi, .ls_lo, .fs_hi, .fs_lo, .pix_dly, .pix_val);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk);
      reg_write = 1'b0;
      // Derived outputs follow one edge after the register
      @(negedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(negedge clk);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clk);
      reg_read = 1'b0;
      chk("rvalid", reg_rvalid, 16'h0001);
      chk(n, reg_rdata, e);
   endtask : rd

   task automatic close_out;
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////
   // Row 40 periods, active 20; frame high 81, low 54; one period is 2 clk
   task automatic t_timing;
      repeat (700) @(negedge clk);
      chk("line high", ls_hi, 16'd40);
      chk("line low", ls_lo, 16'd40);
      chk("frame high", fs_hi, 16'd162);
      chk("frame low", fs_lo, 16'd108);
      chk("first pixel", pix_dly, 16'd22);
      chk("pixel value", pix_val, 16'h00E2);
   endtask : t_timing

   task automatic t_regs;
      rd(8'h55, 8'h00, "float");
      rd(8'h80, 8'h00, "init one");
      rd(8'h83, 8'h1E, "offset");
      rd(8'h85, 8'h81, "power");
      rd(8'h88, 8'h00, "init two");
      rd(8'h10, 8'h00, "unmapped");
      chk("offset out", offset_compensation_value, 16'h001E);
   endtask : t_regs

   task automatic t_init;
      wr(8'h80, 8'h05);
      chk("cal closed", calibration_enable, 16'h0000);
      rd(8'h80, 8'h00, "init one closed");
      wr(8'h88, 8'h01);
      chk("init active", init_regs_active, 16'h0001);
      wr(8'h80, 8'h05);
      chk("cal on", calibration_enable, 16'h0001);
      rd(8'h80, 8'h05, "init one open");
      wr(8'h80, 8'h00);
      chk("cal off", calibration_enable, 16'h0000);
      wr(8'h88, 8'h00);
      chk("init idle", init_regs_active, 16'h0000);
      rd(8'h80, 8'h00, "init one shut");
   endtask : t_init

   task automatic t_power;
      wr(8'h85, 8'h82);
      chk("low current", power_down_low_current, 16'h0001);
      wr(8'h85, 8'h81);
      chk("normal current", power_down_low_current, 16'h0000);
      rd(8'h85, 8'h81, "power back");
   endtask : t_power

   task automatic t_offset;
      wr(8'h83, 8'h20);
      chk("offset new", offset_compensation_value, 16'h0020);
      repeat (600) @(negedge clk);
      chk("pixel new", pix_val, 16'h00E0);
   endtask : t_offset

   // Enables packed as frame, line, clock, data, external
   task automatic t_float;
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h1F, "float bits");
      chk("all float", {frame_sync_oe_n, line_sync_oe_n, pixel_clock_oe_n, pixel_data_oe_n,
         external_sync_oe_n}, 16'h001F);
      master_mode = 1'b1;
      @(negedge clk);
      @(negedge clk);
      chk("keep all", {frame_sync_oe_n, line_sync_oe_n, pixel_clock_oe_n, pixel_data_oe_n,
         external_sync_oe_n}, 16'h0002);
      wr(8'h55, 8'h15);
      chk("keep some", {frame_sync_oe_n, line_sync_oe_n, pixel_clock_oe_n, pixel_data_oe_n,
         external_sync_oe_n}, 16'h0016);
      wr(8'h55, 8'h00);
      chk("driving", {frame_sync_oe_n, line_sync_oe_n, pixel_clock_oe_n, pixel_data_oe_n,
         external_sync_oe_n}, 16'h0000);
   endtask : t_float

   // The source never lets go, so outside the pixel window the buffer fills
   task automatic t_misc;
      ext_sync_in = 1'b1;
      repeat (3) @(negedge clk);
      chk("ext sync", external_sync, 16'h0001);
      ext_sync_in = 1'b0;
      for (int i = 0; i < 100 && adc_ready !== 1'b0; i++) @(negedge clk);
      chk("buffer full", adc_ready, 16'h0000);
   endtask : t_misc

   // Second reset in mid-run with black pixels masked; spans 12 and 28 periods
   task automatic t_noblack;
      @(negedge clk);
      reset              = 1'b1;
      black_pixel_enable = 1'b0;
      repeat (5) @(negedge clk);
      reset = 1'b0;
      chk("pclk at release", pixel_clock, 16'h0000);
      @(negedge clk);
      chk("pclk first high", pixel_clock, 16'h0001);
      repeat (300) @(negedge clk);
      chk("line high nb", ls_hi, 16'd24);
      chk("line low nb", ls_lo, 16'd56);
      chk("first pixel nb", pix_dly, 16'd6);
      chk("offset reset", offset_compensation_value, 16'h001E);
   endtask : t_noblack

   initial begin
      repeat (5) @(negedge clk);
      reset = 1'b0;
      t_timing();
      t_regs();
      t_init();
      t_power();
      t_offset();
      t_float();
      t_misc();
      t_noblack();
      close_out();
   end

   // Whole run is about 1700 cycles
   initial begin
      repeat (6000) @(posedge clk);
      miscompares++;
      close_out();
   end
endmodule : tb_video_port_sync_and_init_ctrl
